// ---- logic/trib_map_pkg.sv ----
package trib_map_pkg;

  localparam int          T1_COLS         = 3;
  localparam int          E1_COLS         = 4;
  localparam int          BLOCK_ROWS      = 9;
  localparam int          MF_BLOCKS       = 4;
  localparam int          T1_CHANS        = 24;
  localparam int          E1_SLOTS        = 32;
  localparam int          E1_CAS_CHANS    = 30;
  localparam int          T1_SIG_FRAMES   = 24;
  localparam int          T1_PHASE_FRAMES = 6;
  localparam int          E1_SIG_FRAMES   = 16;
  localparam int          E1_CAS_LAST     = 15;
  localparam int          E1_CAS_SLOT     = 16;
  localparam int          E1_CAS_OFFSET   = 15;
  localparam logic [1:0]  V3_BLOCK        = 2'h2;
  localparam logic [1:0]  V4_BLOCK        = 2'h3;
  localparam logic [7:0]  ZERO_OCTET      = 8'h00;
  localparam logic [7:0]  PHASE_IDLE      = 8'h00;
  localparam logic [7:0]  PHASE_CAS_MARK  = 8'hc0;
  localparam int          LR_ALM_BIT      = 7;
  localparam int          LR_RATE_LSB     = 4;
  localparam logic [1:0]  RATE_NOMINAL    = 2'h0;
  localparam logic [1:0]  RATE_FAST       = 2'h1;
  localparam logic [1:0]  RATE_SLOW       = 2'h2;

  typedef enum logic [2:0] {
    K_VPTR = 3'h0,
    K_V5R  = 3'h1,
    K_SIG  = 3'h3,
    K_DATA = 3'h2,
    K_RFIX = 3'h6
  } kind_type;

  typedef enum logic [1:0] {
    SIG_TWO     = 2'h0,
    SIG_FOUR    = 2'h1,
    SIG_SIXTEEN = 2'h3
  } sig_mode_type;

  typedef struct packed {
    kind_type   kind;
    logic [4:0] ts;
  } pos_type;

  typedef struct packed {
    logic [E1_CAS_CHANS-1:0] a;
    logic [E1_CAS_CHANS-1:0] b;
    logic [E1_CAS_CHANS-1:0] c;
    logic [E1_CAS_CHANS-1:0] d;
  } cas_type;

endpackage

// ---- logic/slot_store.sv ----
`timescale 1ns/1ps
module slot_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             clk_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             rd_en_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_chk
    $error("slot_store: DEPTH exceeds address range");
  end

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rd_en_i) begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

endmodule

// ---- logic/trib_mapper.sv ----
// Notes on behaviour
// - T1: 84 tributaries, three columns; pointer, signalling octet, DS0 1..24 per block.
// - T1 signalling octet carries framing bit F, two phase bits, four signalling bits.
// - Last bit of the T1 signalling octet is zero; signalling content optional.
// - Phase bits 00,01,10,11 for A,B,C,D; six frames each, four channels per frame.
// - Four-state repeats A,B in C,D; two-state carries only A bits.
// - With sync alignment, DS0 octets sit at fixed positions, no floating.
// - With sync alignment, phase 00 row A1-A4 coincides with the multiframe pulse.
// - Framing bit alignment to signalling phase is arbitrary; not assumed fixed.
// - Robbed-bit signalling in DS0s has arbitrary alignment to the phase bits.
// - T1 rate justified through V3; rate and alarm optionally in V4 link-rate octet.
// - Synchronous T1: no V3 justification, V4 clock rate field ignored.
// - E1: 63 tributaries, four columns; pointer, phase octet, TS0..31, final R.
// - Add side tolerates E1 framing bits without valid framing information.
// - Unframed E1 uses same octet map without timeslot alignment.
// - V5 and all R octets are driven to zero.
// - V3 carries data only during a rate adjustment, marked by payload valid.
// - Floating octets move at most one octet per multiframe; V5 marks start.
// - Fast tributary: frame advanced one octet, surplus octet sent in V3.
// - Slow tributary: stuff octet right after V3, following octet delayed.
// - E1 CAS: TS16 carries ABCD; frame n gives channel n then n plus 15.
// - E1 phase octet is 00h except C0h in the frame for channels 15 and 30.
// - Synchronous E1: no V3 justification, V4 clock rate field unused.
// - E1 with sync alignment: every timeslot at its fixed mapped position.
`timescale 1ns/1ps
module trib_mapper
  import trib_map_pkg::*;
#(
  parameter int SLOTS = E1_SLOTS
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         slot_i,
  input  wire logic         e1_mode_i,
  input  wire logic         sync_alignment_select_i,
  input  wire logic         cas_en_i,
  input  wire sig_mode_type sig_mode_i,
  input  wire cas_type      sig_i,
  input  wire logic         framing_bit_i,
  input  wire logic         alarm_i,
  input  wire logic         just_fast_i,
  input  wire logic         just_slow_i,
  input  wire logic         wr_en_i,
  input  wire logic [4:0]   wr_addr_i,
  input  wire logic [7:0]   wr_data_i,
  input  wire logic [7:0]   add_data_i,
  input  wire logic         add_payload_valid_i,
  output logic      [7:0]   drop_data_o,
  output logic              drop_octet_strobe_o,
  output logic              drop_payload_valid_o,
  output logic              drop_frame_start_indicator_o,
  output logic              drop_multiframe_pulse_o,
  output logic      [7:0]   add_octet_o,
  output logic      [4:0]   add_ts_o,
  output logic              add_octet_valid_o
);

  if (SLOTS != E1_SLOTS) begin : g_chk
    $error("trib_mapper: SLOTS must equal the E1 timeslot count");
  end

  function automatic pos_type decode_pos(input logic e1, input logic [3:0] row,
                                         input logic [1:0] col);
    pos_type    p;
    logic [7:0] idx;
    p.kind = K_DATA;
    p.ts   = 5'h00;
    idx    = 8'h00;
    if (row == 4'h0) begin
      unique case (col)
        2'h0: p.kind = K_VPTR;
        2'h1: p.kind = K_V5R;
        2'h2: p.kind = K_SIG;
        2'h3: p.kind = K_DATA;
      endcase
    end else if (e1 && row == 4'h8 && col == 2'h3) begin
      p.kind = K_RFIX;
    end else begin
      if (e1) begin
        idx = 8'((row - 4'h1) * 4 + col + 1);
      end else begin
        idx = 8'((row - 4'h1) * 3 + col);
      end
      p.ts = idx[4:0];
    end
    return p;
  endfunction

  function automatic logic [3:0] nibble(input cas_type s, input logic [4:0] i);
    return {s.a[i], s.b[i], s.c[i], s.d[i]};
  endfunction

  // Position of the current slot within the 2 kHz multiframe
  logic [1:0] col_q;
  logic [3:0] row_q;
  logic [1:0] blk_q;
  logic [4:0] sigf_q;
  logic [4:0] ptr_q;
  logic       fast_q;
  logic       slow_q;
  pos_type    pos;
  logic       last_col;
  logic       last_row;
  logic       mf_start;
  logic       take_data;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;

  assign pos       = decode_pos(e1_mode_i, row_q, col_q);
  assign last_col  = e1_mode_i ? (col_q == 2'(E1_COLS - 1)) : (col_q == 2'(T1_COLS - 1));
  assign last_row  = (row_q == 4'(BLOCK_ROWS - 1));
  assign mf_start  = slot_i && col_q == 2'h0 && row_q == 4'h0 && blk_q == 2'h0;
  assign take_data = pos.kind == K_DATA ||
                     (pos.kind == K_VPTR && blk_q == V3_BLOCK && fast_q);
  assign rd_addr   = sync_alignment_select_i ? pos.ts : ptr_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      col_q <= 2'h0;
      row_q <= 4'h0;
      blk_q <= 2'h0;
    end else if (slot_i) begin
      col_q <= last_col ? 2'h0 : col_q + 2'h1;
      if (last_col) begin
        row_q <= last_row ? 4'h0 : row_q + 4'h1;
        if (last_row) begin
          blk_q <= blk_q + 2'h1;
        end
      end
    end
  end

  // Signalling frame count; in sync mode it is snapped to the multiframe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sigf_q <= 5'h00;
    end else if (mf_start && sync_alignment_select_i) begin
      sigf_q <= {sigf_q[4:2], 2'h0};
    end else if (slot_i && last_col && last_row) begin
      if (e1_mode_i) begin
        sigf_q <= (sigf_q >= 5'(E1_SIG_FRAMES - 1)) ? 5'h00 : sigf_q + 5'h1;
      end else begin
        sigf_q <= (sigf_q >= 5'(T1_SIG_FRAMES - 1)) ? 5'h00 : sigf_q + 5'h1;
      end
    end
  end

  // Justification is chosen once per multiframe, never in sync mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_q <= 1'b0;
      slow_q <= 1'b0;
    end else if (mf_start) begin
      fast_q <= just_fast_i && !just_slow_i && !sync_alignment_select_i;
      slow_q <= just_slow_i && !just_fast_i && !sync_alignment_select_i;
    end
  end

  // Free-running read pointer: the floating frame follows the data it consumes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= 5'h00;
    end else if (slot_i && take_data) begin
      if (!e1_mode_i && rd_addr >= 5'(T1_CHANS - 1)) begin
        ptr_q <= 5'h00;
      end else begin
        ptr_q <= rd_addr + 5'h1;
      end
    end
  end

  slot_store #(.WIDTH(8), .DEPTH(SLOTS), .AW(5)) slot_store_inst (
    .clk_i     (clk_i),
    .wr_en_i   (wr_en_i),
    .wr_addr_i (wr_addr_i),
    .wr_data_i (wr_data_i),
    .rd_en_i   (slot_i),
    .rd_addr_i (rd_addr),
    .rd_data_o (rd_data)
  );

  // Stage one: hold the decoded slot while the store answers
  logic       s1_q;
  pos_type    s1_pos_q;
  logic [1:0] s1_blk_q;
  logic [4:0] s1_sigf_q;
  logic       s1_mf_q;
  logic       s1_f_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
    end else begin
      s1_q <= slot_i;
    end
  end

  // Kind is cleared so the octet decode never sees an unknown after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_pos_q  <= '{kind: K_VPTR, ts: 5'h00};
    end else if (slot_i) begin
      s1_pos_q  <= '{kind: pos.kind, ts: rd_addr};
      s1_blk_q  <= blk_q;
      s1_sigf_q <= sigf_q;
      s1_mf_q   <= mf_start;
      s1_f_q    <= framing_bit_i;
    end
  end

  // Octet forming
  logic [2:0] t1_phase;
  logic [4:0] t1_base;
  logic [7:0] t1_sig_oct;
  logic [3:0] t1_s;
  logic [4:0] e1_ch;
  logic [7:0] lr_oct;
  logic [7:0] oct_d;
  logic       pv_d;
  logic       fsi_d;

  always_comb begin
    t1_phase = 3'(s1_sigf_q / T1_PHASE_FRAMES);
    t1_base  = 5'((s1_sigf_q - t1_phase * T1_PHASE_FRAMES) * 4);
    for (int k = 0; k < 4; k++) begin
      unique case ({sig_mode_i == SIG_SIXTEEN ? 1'b0 : 1'b1, t1_phase[1:0]})
        3'b000, 3'b100: t1_s[3-k] = sig_i.a[t1_base + 5'(k)];
        3'b001, 3'b101: t1_s[3-k] = sig_i.b[t1_base + 5'(k)];
        3'b010:         t1_s[3-k] = sig_i.c[t1_base + 5'(k)];
        3'b011:         t1_s[3-k] = sig_i.d[t1_base + 5'(k)];
        3'b110:         t1_s[3-k] = sig_i.a[t1_base + 5'(k)];
        default:        t1_s[3-k] = sig_i.b[t1_base + 5'(k)];
      endcase
    end
    if (sig_mode_i == SIG_TWO && t1_phase != 3'h0) begin
      t1_s = 4'h0;
    end
    if (cas_en_i) begin
      t1_sig_oct = {t1_phase[1:0], t1_s, s1_f_q, 1'b0};
    end else begin
      t1_sig_oct = {6'h00, s1_f_q, 1'b0};
    end
  end

  assign e1_ch  = s1_sigf_q - 5'h1;
  assign lr_oct = {alarm_i, 1'b0,
                   sync_alignment_select_i ? RATE_NOMINAL :
                   fast_q ? RATE_FAST : slow_q ? RATE_SLOW : RATE_NOMINAL, 4'h0};

  always_comb begin
    oct_d = ZERO_OCTET;
    pv_d  = 1'b1;
    fsi_d = 1'b0;
    unique case (s1_pos_q.kind)
      K_VPTR: begin
        pv_d = 1'b0; // V1/V2 left empty for listeners to ignore
        if (s1_blk_q == V4_BLOCK) begin
          oct_d = lr_oct;
        end else if (s1_blk_q == V3_BLOCK && fast_q) begin
          oct_d = rd_data;
          pv_d  = 1'b1;
        end
      end
      K_V5R: begin
        fsi_d = (s1_blk_q == 2'h0);
        pv_d  = !(s1_blk_q == V3_BLOCK && slow_q);
      end
      K_SIG: begin
        if (e1_mode_i) begin
          oct_d = (s1_sigf_q == 5'(E1_CAS_LAST)) ? PHASE_CAS_MARK : PHASE_IDLE;
        end else begin
          oct_d = t1_sig_oct;
        end
      end
      K_DATA: begin
        if (e1_mode_i && cas_en_i && s1_pos_q.ts == 5'(E1_CAS_SLOT)) begin
          if (s1_sigf_q != 5'h00) begin
            oct_d = {nibble(sig_i, e1_ch), nibble(sig_i, e1_ch + 5'(E1_CAS_OFFSET))};
          end
        end else begin
          oct_d = rd_data;
        end
      end
      K_RFIX: oct_d = ZERO_OCTET;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_data_o                  <= ZERO_OCTET;
      drop_octet_strobe_o          <= 1'b0;
      drop_payload_valid_o         <= 1'b0;
      drop_frame_start_indicator_o <= 1'b0;
      drop_multiframe_pulse_o      <= 1'b0;
    end else begin
      drop_data_o                  <= s1_q ? oct_d : ZERO_OCTET;
      drop_octet_strobe_o          <= s1_q;
      drop_payload_valid_o         <= s1_q && pv_d;
      drop_frame_start_indicator_o <= s1_q && fsi_d;
      drop_multiframe_pulse_o      <= s1_q && s1_mf_q;
    end
  end

  // Add side: framing bits are passed as found, never checked
  logic add_take;
  assign add_take = slot_i && add_payload_valid_i &&
                    (pos.kind == K_DATA ||
                     (pos.kind == K_VPTR && blk_q == V3_BLOCK && !sync_alignment_select_i)) &&
                    !(e1_mode_i && cas_en_i && pos.ts == 5'(E1_CAS_SLOT) &&
                      sigf_q == 5'h00);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      add_octet_o       <= ZERO_OCTET;
      add_ts_o          <= 5'h00;
      add_octet_valid_o <= 1'b0;
    end else begin
      add_octet_valid_o <= add_take;
      if (add_take) begin
        add_octet_o <= add_data_i;
        add_ts_o    <= pos.ts;
      end
    end
  end

  // Helper state for the checks below
  kind_type   o_kind_q;
  logic [1:0] o_blk_q;
  logic [4:0] o_sigf_q;
  always_ff @(posedge clk_i) begin
    o_kind_q <= s1_pos_q.kind;
    o_blk_q  <= s1_blk_q;
    o_sigf_q <= s1_sigf_q;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_sig_r_zero;
    drop_octet_strobe_o && o_kind_q == K_SIG && !e1_mode_i |-> drop_data_o[0] == 1'b0;
  endproperty
  a_sig_r_zero: assert property (p_sig_r_zero) else $error("R bit not zero");

  property p_v5_zero;
    drop_frame_start_indicator_o |-> drop_data_o == ZERO_OCTET && drop_payload_valid_o;
  endproperty
  a_v5_zero: assert property (p_v5_zero) else $error("V5 octet not zero");

  property p_pp_value;
    drop_octet_strobe_o && o_kind_q == K_SIG && e1_mode_i |->
      (o_sigf_q == 5'h0f) ? drop_data_o == 8'hc0 : drop_data_o == 8'h00;
  endproperty
  a_pp_value: assert property (p_pp_value) else $error("bad E1 phase octet");

  property p_sync_no_just;
    (sync_alignment_select_i && $stable(sync_alignment_select_i)) [*2] ##0
      drop_octet_strobe_o && o_kind_q == K_VPTR && o_blk_q == 2'h2 |-> !drop_payload_valid_o;
  endproperty
  a_sync_no_just: assert property (p_sync_no_just) else $error("V3 used in sync");

  property p_sync_phase;
    sync_alignment_select_i && $past(sync_alignment_select_i, 3) &&
      drop_octet_strobe_o && o_kind_q == K_SIG && o_blk_q == 2'h0 |-> o_sigf_q[1:0] == 2'h0;
  endproperty
  a_sync_phase: assert property (p_sync_phase) else $error("phase off multiframe");

  property p_one_just;
    $changed(fast_q) || $changed(slow_q) |-> $past(mf_start) && !(fast_q && slow_q);
  endproperty
  a_one_just: assert property (p_one_just) else $error("justification mid multiframe");

  property p_fast_v3;
    slot_i && pos.kind == K_VPTR && blk_q == 2'h2 && fast_q |->
      ##2 drop_payload_valid_o && !drop_frame_start_indicator_o;
  endproperty
  a_fast_v3: assert property (p_fast_v3) else $error("no data in V3");

  property p_slow_stuff;
    slot_i && pos.kind == K_V5R && blk_q == 2'h2 && slow_q |->
      ##2 drop_octet_strobe_o && !drop_payload_valid_o;
  endproperty
  a_slow_stuff: assert property (p_slow_stuff) else $error("no stuff after V3");

  c_fast:  cover property (drop_octet_strobe_o && o_blk_q == 2'h2 && drop_payload_valid_o &&
                           o_kind_q == K_VPTR);
  c_slow:  cover property (slow_q && drop_octet_strobe_o && !drop_payload_valid_o &&
                           o_kind_q == K_V5R);
  c_cas15: cover property (drop_octet_strobe_o && drop_data_o == 8'hc0);
  c_add:   cover property (add_octet_valid_o);

endmodule

// ---- testbench/trib_bus_partner.sv ----
`timescale 1ns/1ps
module trib_bus_partner (
  input  wire logic       clk_i,
  input  wire logic [7:0] drop_data_i,
  input  wire logic       drop_strobe_i,
  input  wire logic       drop_pv_i,
  input  wire logic       drop_fsi_i,
  input  wire logic       drop_mfp_i,
  input  wire logic [7:0] add_octet_i,
  input  wire logic [4:0] add_ts_i,
  input  wire logic       add_valid_i,
  output logic            slot_o,
  output logic      [7:0] add_data_o,
  output logic            add_pv_o
);
  logic [10:0] drec [0:1023];
  logic [12:0] arec [0:1023];
  int          nd = 0;
  int          na = 0;

  initial begin
    slot_o = 1'b0;
    add_data_o = 8'h00;
    add_pv_o = 1'b0;
  end

  // Everything is logged; V1 and V2 content is never interpreted
  always @(posedge clk_i) begin
    if (drop_strobe_i) begin
      drec[nd] <= {drop_mfp_i, drop_fsi_i, drop_pv_i, drop_data_i};
      nd <= nd + 1;
    end
    if (add_valid_i) begin
      arec[na] <= {add_ts_i, add_octet_i};
      na <= na + 1;
    end
  end

  task automatic run(input int n, input int gap, input int cols);
    nd = 0;
    na = 0;
    for (int s = 0; s < n; s++) begin
      @(posedge clk_i);
      #1;
      slot_o = 1'b1;
      add_data_o = s[7:0] ^ 8'h3c;
      // Pointer octets carry no payload from this side, except V3
      add_pv_o = (s % cols) != 0 || ((s / cols) % 9) != 0 || ((s / (9 * cols)) % 4) == 2;
      repeat (gap) begin
        @(posedge clk_i);
        #1;
        slot_o = 1'b0;
        add_data_o = ~add_data_o;
        add_pv_o = ~add_pv_o;
      end
    end
    @(posedge clk_i);
    #1;
    slot_o = 1'b0;
    add_data_o = ~add_data_o;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
endmodule

// ---- testbench/test_trib_mapper.sv ----
`timescale 1ns/1ps
module test_trib_mapper
  import trib_map_pkg::*;
;
  logic         clk_i;
  logic         rst_i;
  logic         e1;
  logic         sync;
  logic         cas;
  sig_mode_type sig_mode;
  cas_type      sig;
  logic         fbit;
  logic         alarm;
  logic         fast;
  logic         slow;
  logic         wr_en;
  logic [4:0]   wr_addr;
  logic [7:0]   wr_data;
  logic [7:0]   add_data;
  logic         add_pv;
  logic         slot;
  logic [7:0]   drop_data;
  logic         drop_strobe;
  logic         drop_pv;
  logic         drop_fsi;
  logic         drop_mfp;
  logic [7:0]   add_octet;
  logic [4:0]   add_ts;
  logic         add_valid;
  int           n_mismatch = 0;
  int           checked = 0;

  trib_mapper trib_mapper_inst (
    .clk_i(clk_i), .rst_i(rst_i), .slot_i(slot), .e1_mode_i(e1),
    .sync_alignment_select_i(sync), .cas_en_i(cas), .sig_mode_i(sig_mode), .sig_i(sig),
    .framing_bit_i(fbit), .alarm_i(alarm), .just_fast_i(fast), .just_slow_i(slow),
    .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .add_data_i(add_data),
    .add_payload_valid_i(add_pv), .drop_data_o(drop_data), .drop_octet_strobe_o(drop_strobe),
    .drop_payload_valid_o(drop_pv), .drop_frame_start_indicator_o(drop_fsi),
    .drop_multiframe_pulse_o(drop_mfp), .add_octet_o(add_octet), .add_ts_o(add_ts),
    .add_octet_valid_o(add_valid));

  trib_bus_partner trib_bus_partner_inst (
    .clk_i(clk_i), .drop_data_i(drop_data), .drop_strobe_i(drop_strobe),
    .drop_pv_i(drop_pv), .drop_fsi_i(drop_fsi), .drop_mfp_i(drop_mfp),
    .add_octet_i(add_octet), .add_ts_i(add_ts), .add_valid_i(add_valid),
    .slot_o(slot), .add_data_o(add_data), .add_pv_o(add_pv));

  always #5 clk_i = ~clk_i;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] store_val(input int a);
    return {a[4:0], 3'h5};
  endfunction

  function automatic logic [7:0] t1_sig(input int f);
    int         p;
    int         ch;
    int         sel;
    logic [3:0] sv;
    p = f / 6;
    ch = 4 * (f % 6);
    sel = (sig_mode == SIG_SIXTEEN) ? p : (sig_mode == SIG_FOUR) ? p % 2 : (p == 0) ? 0 : 4;
    for (int i = 0; i < 4; i++) begin
      case (sel)
        0: sv[3-i] = sig.a[ch+i];
        1: sv[3-i] = sig.b[ch+i];
        2: sv[3-i] = sig.c[ch+i];
        3: sv[3-i] = sig.d[ch+i];
        default: sv[3-i] = 1'b0;
      endcase
    end
    return cas ? {p[1:0], sv, fbit, 1'b0} : {6'h00, fbit, 1'b0};
  endfunction

  function automatic logic [7:0] e1_sig(input int f);
    if (f == 0) return 8'h00;
    return {sig.a[f-1], sig.b[f-1], sig.c[f-1], sig.d[f-1],
            sig.a[f+14], sig.b[f+14], sig.c[f+14], sig.d[f+14]};
  endfunction

  // Packs {add taken, ts, data known, mf pulse, frame start, payload valid, octet}
  function automatic logic [17:0] expect_slot(input int s);
    int         cols;
    int         b;
    int         r;
    int         c;
    int         f;
    int         n;
    logic [7:0] d;
    logic       pv;
    logic       kn;
    logic       tk;
    cols = e1 ? 4 : 3;
    b = (s / (9 * cols)) % 4;
    r = (s / cols) % 9;
    c = s % cols;
    f = (4 * (s / (36 * cols)) + b) % (e1 ? 16 : 24);
    n = (r == 0) ? 0 : (r - 1) * cols + c + 1;
    d = 8'h00;
    pv = 1'b0;
    kn = 1'b1;
    tk = 1'b0;
    if (r == 0 && c == 0) begin
      pv = (b == 2) && fast && !sync;
      kn = !pv;
      tk = (b == 2) && !sync;
      if (b == 3) d = {alarm, 1'b0, sync ? 2'h0 : fast ? 2'h1 : slow ? 2'h2 : 2'h0, 4'h0};
    end else if (r == 0 && c == 1) begin
      pv = !((b == 2) && slow && !sync);
    end else if (r == 0 && c == 2) begin
      pv = 1'b1;
      d = e1 ? ((f == 15) ? 8'hc0 : 8'h00) : t1_sig(f);
    end else if (n < 32) begin
      pv = 1'b1;
      tk = !(e1 && cas && n == 16 && f == 0);
      d = (e1 && cas && n == 16) ? e1_sig(f) : store_val(e1 ? n : n - 1);
      kn = sync && !(e1 && cas && n > 16);
    end else begin
      pv = 1'b1;
    end
    return {tk, 5'((r == 0 || e1) ? n : n - 1), kn, (s % (36 * cols)) == 0,
            b == 0 && r == 0 && c == 1, pv, d};
  endfunction

  task automatic run_cfg(input int mf, input int gap);
    int          n;
    int          k;
    logic [17:0] e;
    logic [7:0]  ao;
    n = mf * 36 * (e1 ? 4 : 3);
    k = 0;
    @(posedge clk_i);
    #1;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    for (int a = 0; a < 32; a++) begin
      wr_en = 1'b1;
      wr_addr = a[4:0];
      wr_data = store_val(a);
      @(posedge clk_i);
      #1;
    end
    wr_en = 1'b0;
    trib_bus_partner_inst.run(n, gap, e1 ? 4 : 3);
    check("drop count", 16'(trib_bus_partner_inst.nd), 16'(n));
    for (int s = 0; s < n; s++) begin
      e = expect_slot(s);
      if (e[11]) begin
        check("drop octet", trib_bus_partner_inst.drec[s], e[10:0]);
      end else begin
        check("drop flags", trib_bus_partner_inst.drec[s][10:8], e[10:8]);
      end
      if (e[17]) begin
        ao = s[7:0] ^ 8'h3c;
        check("add octet", trib_bus_partner_inst.arec[k], {e[16:12], ao});
        k++;
      end
    end
    check("add count", 16'(trib_bus_partner_inst.na), 16'(k));
  endtask

  // Sync mode: fixed DS0 positions, phase 00 row starts at the multiframe
  task automatic t1_signalling();
    e1 = 1'b0;
    sync = 1'b1;
    cas = 1'b1;
    fbit = 1'b1;
    sig_mode = SIG_TWO;
    run_cfg(6, 0);
    sig_mode = SIG_FOUR;
    fbit = 1'b0;
    run_cfg(6, 0);
    sig_mode = SIG_SIXTEEN;
    run_cfg(6, 0);
    cas = 1'b0;
    fbit = 1'b1;
    run_cfg(1, 0);
  endtask

  task automatic e1_timeslots();
    e1 = 1'b1;
    cas = 1'b0;
    run_cfg(1, 2);
    cas = 1'b1;
    run_cfg(4, 0);
  endtask

  task automatic justification();
    e1 = 1'b0;
    sync = 1'b0;
    alarm = 1'b1;
    fast = 1'b1;
    run_cfg(1, 0);
    fast = 1'b0;
    slow = 1'b1;
    alarm = 1'b0;
    run_cfg(1, 0);
    slow = 1'b0;
    run_cfg(1, 0);
    sync = 1'b1;
    fast = 1'b1;
    run_cfg(1, 0);
    e1 = 1'b1;
    fast = 1'b0;
    slow = 1'b1;
    run_cfg(1, 0);
  endtask

  // The whole sequence needs about 42 us; about five times that means a hang
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    e1 = 1'b0;
    sync = 1'b1;
    cas = 1'b0;
    sig_mode = SIG_TWO;
    sig = {30'h15a5c3e9, 30'h0f0f1234, 30'h2468ace1, 30'h3b9a0157};
    fbit = 1'b0;
    alarm = 1'b0;
    fast = 1'b0;
    slow = 1'b0;
    wr_en = 1'b0;
    wr_addr = 5'h00;
    wr_data = 8'h00;
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t1_signalling();
    e1_timeslots();
    justification();
    final_report();
  end
endmodule
